// file: src/ftpwm_pkg.sv
// package: register map, modes, fields and timing of the functional timer
package ftpwm_pkg;
  localparam int CNT_W = 16;
  localparam int AW    = 4;

  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_MODE     = 4'h1;
  localparam logic [3:0] ADDR_PERIOD   = 4'h2;
  localparam logic [3:0] ADDR_CMP_A    = 4'h3;
  localparam logic [3:0] ADDR_CMP_B    = 4'h4;
  localparam logic [3:0] ADDR_DEAD     = 4'h5;
  localparam logic [3:0] ADDR_COUNTER  = 4'h6;
  localparam logic [3:0] ADDR_TRIG     = 4'h7;
  localparam logic [3:0] ADDR_INT_STAT = 4'h8;
  localparam logic [3:0] ADDR_INT_CLR  = 4'h9;
  localparam logic [3:0] ADDR_INT_MASK = 4'ha;

  // ctrl register bits
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_STOP = 1;

  // mode register: [1:0] mode, [2] one-shot
  localparam logic [1:0] MODE_TIMER    = 2'h0;
  localparam logic [1:0] MODE_DUAL_PWM = 2'h1;
  localparam logic [1:0] MODE_DEAD_PWM = 2'h2;
  localparam int MODE_ONESHOT = 2;

  // trigger config fields
  localparam int TRG_EVENT_EN   = 0;
  localparam int TRG_EMG_EN     = 1;
  localparam int TRG_SAMPLE_BYP = 2;
  localparam int TRG_START_LVL  = 3;
  localparam int TRG_SRC_LSB    = 4;
  localparam int TRG_EMG_LSB    = 6;
  localparam int TRG_SEL_W      = 2;
  localparam int NUM_TRIG       = 4;

  // interrupt status bits
  localparam int INT_PERIOD = 0;
  localparam int INT_CMP_A  = 1;
  localparam int INT_CMP_B  = 2;
  localparam int INT_EMG    = 3;
  localparam int INT_W      = 4;

  localparam logic [15:0] PERIOD_MIN = 16'h0001;
  localparam logic [15:0] ALL_ONES   = 16'hffff;
  localparam logic [15:0] RST_ZERO   = 16'h0000;
  localparam logic [15:0] RST_PERIOD = 16'hffff;
endpackage

// file: src/ftpwm_trig_if.sv
// interface: synchronised trigger levels and edges toward the counter
`timescale 1ns/1ns
interface ftpwm_trig_if #(parameter int N = 4);
  logic [N-1:0] level;
  logic [N-1:0] rise;
  modport filt (output level, output rise);
  modport core (input level, input rise);
endinterface

// file: src/ftpwm_trig_filter.sv
// module: trigger input sampling, optionally bypassed
`timescale 1ns/1ns
module ftpwm_trig_filter #(
  parameter int N = 4
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         bypass,
  input  wire logic [N-1:0] trig_in,
  ftpwm_trig_if.filt        tif
);
  logic [N-1:0] s1;
  logic [N-1:0] s2;
  logic [N-1:0] lvl;
  logic [N-1:0] next_s1;
  logic [N-1:0] next_s2;
  logic [N-1:0] next_lvl;

  always_comb
  begin
    next_s1 = trig_in;
    next_s2 = s1;
    next_lvl = lvl;
    for (int i = 0; i < N; i++)
    begin
      if (bypass)
        next_lvl[i] = trig_in[i];
      // a level must hold two samples before it is believed
      else if (s1[i] == s2[i])
        next_lvl[i] = s2[i];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1  <= '0;
      s2  <= '0;
      lvl <= '0;
    end
    else
    begin
      s1  <= next_s1;
      s2  <= next_s2;
      lvl <= next_lvl;
    end
  end

  assign tif.level = lvl;
  assign tif.rise  = next_lvl & ~lvl;
endmodule

// file: src/ftpwm_top.sv
// module: 16-bit functional timer with timer, pwm and one-shot modes
// Summary of operation
// - writing zero to the period stores one; reads then return one.
// - same emergency and event source with both enables holds counter.
// - one-shot level start keeps restarting from zero despite stop.
// - a trigger may fire right after writing the trigger config.
// - no new interrupt request forwarded while status is nonzero.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module ftpwm_top #(
  parameter int NUM_TRIG = ftpwm_pkg::NUM_TRIG
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire logic [3:0]           addr,
  input  wire logic [15:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [15:0]          rdata,
  input  wire logic [NUM_TRIG-1:0]  trig_in,
  output logic                      timer_output_primary,
  output logic                      timer_output_complement,
  output logic                      irq
);
  typedef enum logic [1:0] {
    FTPWM_IDLE = 2'b01,
    FTPWM_RUN  = 2'b10
  } ftpwm_state_t;

  ftpwm_state_t state;
  ftpwm_state_t next_state;
  logic [15:0] period_value;
  logic [15:0] compare_a_value;
  logic [15:0] compare_b_value;
  logic [15:0] dead_time_value;
  logic [15:0] counter_value;
  logic [2:0]  timer_mode_config;
  logic [7:0]  trigger_config;
  logic [3:0]  interrupt_status;
  logic [3:0]  int_mask;
  logic        out_p;
  logic        out_n;
  logic        irq_req;
  logic [15:0] next_period;
  logic [15:0] next_cmp_a;
  logic [15:0] next_cmp_b;
  logic [15:0] next_dead;
  logic [15:0] next_counter;
  logic [2:0]  next_mode;
  logic [7:0]  next_trig;
  logic [3:0]  next_status;
  logic [3:0]  next_mask;
  logic        next_out_p;
  logic        next_out_n;
  logic        next_irq_req;
  logic [15:0] next_rdata;
  logic [3:0]  events;
  logic        trig_start;
  logic        trig_emg;
  logic        start_lvl;
  logic        emg_lock;
  logic        wrap;
  logic        hit_a;
  logic        hit_b;
  logic [15:0] a_end;

  ftpwm_trig_if #(.N(NUM_TRIG)) tif ();

  ftpwm_trig_filter #(.N(NUM_TRIG)) u_filt (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .bypass  (trigger_config[ftpwm_pkg::TRG_SAMPLE_BYP]),
    .trig_in (trig_in),
    .tif     (tif)
  );

  logic [1:0] src_sel;
  logic [1:0] emg_sel;
  assign src_sel = trigger_config[ftpwm_pkg::TRG_SRC_LSB +:
                                  ftpwm_pkg::TRG_SEL_W];
  assign emg_sel = trigger_config[ftpwm_pkg::TRG_EMG_LSB +:
                                  ftpwm_pkg::TRG_SEL_W];

  always_comb
  begin
    start_lvl  = trigger_config[ftpwm_pkg::TRG_EVENT_EN]
                 & tif.level[src_sel];
    trig_start = trigger_config[ftpwm_pkg::TRG_START_LVL] ? start_lvl
                 : (trigger_config[ftpwm_pkg::TRG_EVENT_EN]
                    & tif.rise[src_sel]);
    trig_emg   = trigger_config[ftpwm_pkg::TRG_EMG_EN]
                 & tif.rise[emg_sel];
    emg_lock   = trigger_config[ftpwm_pkg::TRG_EVENT_EN]
                 & trigger_config[ftpwm_pkg::TRG_EMG_EN]
                 & (src_sel == emg_sel);
    wrap  = (state == FTPWM_RUN) && (counter_value >= period_value);
    hit_a = (state == FTPWM_RUN) && (counter_value == compare_a_value);
    hit_b = (state == FTPWM_RUN) && (counter_value == compare_b_value);
    a_end = compare_a_value + dead_time_value;
  end

  always_comb
  begin
    next_state   = state;
    next_counter = counter_value;
    next_out_p   = out_p;
    next_out_n   = out_n;
    events       = '0;
    unique case (state)
      FTPWM_IDLE:
      begin
        // trigger acts on the cycle after a config write
        if (!emg_lock && (trig_start || (wr && addr ==
            ftpwm_pkg::ADDR_CTRL && wdata[ftpwm_pkg::CTRL_RUN])))
        begin
          next_state   = FTPWM_RUN;
          next_counter = ftpwm_pkg::RST_ZERO;
        end
      end
      FTPWM_RUN:
      begin
        next_counter = wrap ? ftpwm_pkg::RST_ZERO : counter_value + 16'h1;
        events[ftpwm_pkg::INT_PERIOD] = wrap;
        events[ftpwm_pkg::INT_CMP_A]  = hit_a;
        events[ftpwm_pkg::INT_CMP_B]  = hit_b;
        unique case (timer_mode_config[1:0])
          ftpwm_pkg::MODE_DUAL_PWM:
          begin
            if (hit_a) next_out_p = 1'b1;
            if (hit_b || wrap) next_out_p = 1'b0;
            next_out_n = ~next_out_p;
          end
          ftpwm_pkg::MODE_DEAD_PWM:
          begin
            next_out_p = (counter_value < compare_a_value) && !wrap;
            next_out_n = (counter_value >= a_end) && !wrap;
          end
          default:
          begin
            if (wrap) next_out_p = ~out_p;
            next_out_n = ~next_out_p;
          end
        endcase
        if (wrap && timer_mode_config[ftpwm_pkg::MODE_ONESHOT])
        begin
          // level start overrides stop in one-shot
          if (!start_lvl || !trigger_config[ftpwm_pkg::TRG_START_LVL])
            next_state = FTPWM_IDLE;
        end
        if (emg_lock || trig_emg ||
            (wr && addr == ftpwm_pkg::ADDR_CTRL &&
             wdata[ftpwm_pkg::CTRL_STOP]))
        begin
          if (!(timer_mode_config[ftpwm_pkg::MODE_ONESHOT] && start_lvl
                && trigger_config[ftpwm_pkg::TRG_START_LVL]) || emg_lock)
          begin
            next_state = FTPWM_IDLE;
            next_out_p = 1'b0;
            next_out_n = 1'b0;
          end
        end
        events[ftpwm_pkg::INT_EMG] = trig_emg;
      end
      default:
        next_state = FTPWM_IDLE;
    endcase
  end

  always_comb
  begin
    next_period = period_value;
    next_cmp_a  = compare_a_value;
    next_cmp_b  = compare_b_value;
    next_dead   = dead_time_value;
    next_mode   = timer_mode_config;
    next_trig   = trigger_config;
    next_mask   = int_mask;
    next_status = interrupt_status;
    if (wr)
    begin
      unique case (addr)
        ftpwm_pkg::ADDR_PERIOD:
          next_period = (wdata == ftpwm_pkg::RST_ZERO) ?
                        ftpwm_pkg::PERIOD_MIN : wdata;
        ftpwm_pkg::ADDR_CMP_A:    next_cmp_a = wdata;
        ftpwm_pkg::ADDR_CMP_B:    next_cmp_b = wdata;
        ftpwm_pkg::ADDR_DEAD:     next_dead  = wdata;
        // mode is ignored while running
        ftpwm_pkg::ADDR_MODE:
          if (state == FTPWM_IDLE) next_mode = wdata[2:0];
        ftpwm_pkg::ADDR_TRIG:     next_trig = wdata[7:0];
        ftpwm_pkg::ADDR_INT_MASK: next_mask = wdata[3:0];
        ftpwm_pkg::ADDR_INT_CLR:  next_status = interrupt_status & ~wdata[3:0];
        default: ;
      endcase
    end
    // set wins over clear
    next_status = next_status | events;
    // request only when status was empty
    next_irq_req = irq_req;
    // drops once no unmasked status bit is left
    if ((next_status & next_mask) == '0)
      next_irq_req = 1'b0;
    else if (interrupt_status == '0 && |(events & int_mask))
      next_irq_req = 1'b1;
    next_rdata = ftpwm_pkg::RST_ZERO;
    if (rd)
    begin
      unique case (addr)
        ftpwm_pkg::ADDR_CTRL:     next_rdata = {15'h0, state == FTPWM_RUN};
        ftpwm_pkg::ADDR_MODE:     next_rdata = {13'h0, timer_mode_config};
        ftpwm_pkg::ADDR_PERIOD:   next_rdata = period_value;
        ftpwm_pkg::ADDR_CMP_A:    next_rdata = compare_a_value;
        ftpwm_pkg::ADDR_CMP_B:    next_rdata = compare_b_value;
        ftpwm_pkg::ADDR_DEAD:     next_rdata = dead_time_value;
        ftpwm_pkg::ADDR_COUNTER:  next_rdata = counter_value;
        ftpwm_pkg::ADDR_TRIG:     next_rdata = {8'h0, trigger_config};
        ftpwm_pkg::ADDR_INT_STAT: next_rdata = {12'h0, interrupt_status};
        ftpwm_pkg::ADDR_INT_MASK: next_rdata = {12'h0, int_mask};
        default:                  next_rdata = ftpwm_pkg::RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state             <= FTPWM_IDLE;
      counter_value     <= ftpwm_pkg::RST_ZERO;
      period_value      <= ftpwm_pkg::RST_PERIOD;
      compare_a_value   <= ftpwm_pkg::ALL_ONES;
      compare_b_value   <= ftpwm_pkg::ALL_ONES;
      dead_time_value   <= ftpwm_pkg::RST_ZERO;
      timer_mode_config <= '0;
      trigger_config    <= '0;
      interrupt_status  <= '0;
      int_mask          <= '0;
      irq_req           <= 1'b0;
      out_p             <= 1'b0;
      out_n             <= 1'b0;
      rdata             <= ftpwm_pkg::RST_ZERO;
    end
    else
    begin
      state             <= next_state;
      counter_value     <= next_counter;
      period_value      <= next_period;
      compare_a_value   <= next_cmp_a;
      compare_b_value   <= next_cmp_b;
      dead_time_value   <= next_dead;
      timer_mode_config <= next_mode;
      trigger_config    <= next_trig;
      interrupt_status  <= next_status;
      int_mask          <= next_mask;
      irq_req           <= next_irq_req;
      out_p             <= next_out_p;
      out_n             <= next_out_n;
      rdata             <= next_rdata;
    end
  end

  assign timer_output_primary    = out_p;
  assign timer_output_complement = out_n;
  assign irq                     = irq_req;
endmodule

// file: dv/ftpwm_trig_src.sv
// model: external trigger sources feeding the timer trigger pins
`timescale 1ns/1ns
module ftpwm_trig_src #(
  parameter int N = 4
) (
  input  wire logic         ref_clk,
  output logic      [N-1:0] trig
);
  initial trig = '0;

  task automatic pulse(input int idx, input int len);
    @(posedge ref_clk);
    trig[idx] <= 1'b1;
    repeat ((len < 2) ? 2 : len) @(posedge ref_clk);
    trig[idx] <= 1'b0;
  endtask

  // level source for level start conditions
  task automatic hold(input int idx, input logic lvl);
    @(posedge ref_clk);
    trig[idx] <= lvl;
  endtask
endmodule

// file: dv/ftpwm_checker.sv
// checker: port-level properties of the functional timer
`timescale 1ns/1ns
module ftpwm_checker #(
  parameter int NUM_TRIG = 4
) (
  input wire logic                ref_clk,
  input wire logic                rstn,
  input wire logic [3:0]          addr,
  input wire logic [15:0]         wdata,
  input wire logic                wr,
  input wire logic                rd,
  input wire logic [15:0]         rdata,
  input wire logic [NUM_TRIG-1:0] trig_in,
  input wire logic                timer_output_primary,
  input wire logic                timer_output_complement,
  input wire logic                irq
);
  logic [15:0] per_q;
  logic [7:0]  cfg_q;
  logic [15:0] next_per_q;
  logic [7:0]  next_cfg_q;
  logic        lock;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  always_comb
  begin
    next_per_q = per_q;
    next_cfg_q = cfg_q;
    if (wr && addr == ftpwm_pkg::ADDR_PERIOD)
      next_per_q = (wdata == 16'h0000) ? 16'h0001 : wdata;
    if (wr && addr == ftpwm_pkg::ADDR_TRIG)
      next_cfg_q = wdata[7:0];
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      per_q <= ftpwm_pkg::RST_PERIOD;
      cfg_q <= 8'h00;
    end
    else
    begin
      per_q <= next_per_q;
      cfg_q <= next_cfg_q;
    end
  end

  assign lock = cfg_q[0] & cfg_q[1] & (cfg_q[5:4] == cfg_q[7:6]);

  period_zero_a: assert property (rd && addr == ftpwm_pkg::ADDR_PERIOD
    |=> rdata == per_q) else $error("period read not as written");
  count_range_a: assert property (rd && addr == ftpwm_pkg::ADDR_COUNTER
    |=> rdata <= per_q) else $error("counter above period");
  lock_stop_a: assert property (lock && rd &&
    addr == ftpwm_pkg::ADDR_CTRL |=> rdata[0] == 1'b0)
    else $error("locked timer running");
  outputs_apart_a: assert property (!(timer_output_primary &&
    timer_output_complement)) else $error("both outputs high");
  irq_hold_a: assert property (irq && !(wr && (addr ==
    ftpwm_pkg::ADDR_INT_CLR || addr == ftpwm_pkg::ADDR_INT_MASK)) |=> irq)
    else $error("irq dropped without clear");
  rd_idle_a: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data without read");
  unmapped_rd_a: assert property (rd && addr > ftpwm_pkg::ADDR_INT_MASK
    |=> rdata == 16'h0000) else $error("unmapped read nonzero");

  cover property ($rose(irq));
  cover property ($rose(timer_output_complement));
  cover property (lock && rd && addr == ftpwm_pkg::ADDR_CTRL);
  cover property (wr && addr == ftpwm_pkg::ADDR_PERIOD && wdata == 16'h0000);
endmodule

bind ftpwm_top ftpwm_checker #(.NUM_TRIG(NUM_TRIG)) u_ftpwm_checker (
  .ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .trig_in(trig_in), .irq(irq),
  .timer_output_primary(timer_output_primary),
  .timer_output_complement(timer_output_complement));

// file: dv/tb_functional_timer_pwm.sv
// testbench: registers, counting, interrupts and trigger start rules
`timescale 1ns/1ns
module tb_functional_timer_pwm;
  typedef struct packed {
    logic [3:0]  a;
    logic [15:0] d;
    logic [15:0] e;
  } ftpwm_row_t;
  logic        ref_clk;
  logic        rstn;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [3:0]  trig_in;
  logic        irq;
  logic        out_p;
  logic        out_n;
  int          hp;
  int          hn;
  int          hb;
  logic [15:0] got;
  int          errors;
  int          check_count;
  ftpwm_row_t  rows [6];

  // each output drives one bench net
  ftpwm_top u_ftpwm_top (.ref_clk(ref_clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .trig_in(trig_in),
    .timer_output_primary(out_p), .timer_output_complement(out_n),
    .irq(irq));
  ftpwm_trig_src u_ftpwm_trig_src (.ref_clk(ref_clk), .trig(trig_in));

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask

  task automatic blk_reset();
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
  endtask

  // two periods of six clocks; counts output highs on settled edges
  task automatic pwm_run(input logic [15:0] mode, input logic [15:0] dead,
                         input int exp_p, input int exp_n);
    blk_reset();
    wr_reg(ftpwm_pkg::ADDR_MODE, mode);
    // period 5 keeps output below 3 MHz
    wr_reg(ftpwm_pkg::ADDR_PERIOD, 16'h0005);
    wr_reg(ftpwm_pkg::ADDR_CMP_A, 16'h0002);
    wr_reg(ftpwm_pkg::ADDR_CMP_B, 16'h0004);
    // dead below A, sum below period
    wr_reg(ftpwm_pkg::ADDR_DEAD, dead);
    wr_reg(ftpwm_pkg::ADDR_CTRL, 16'h0001);
    hp = 0;
    hn = 0;
    hb = 0;
    // outputs follow the counter from the clock after start
    @(posedge ref_clk);
    repeat (12)
    begin
      @(negedge ref_clk);
      if (out_p === 1'b1)
        hp++;
      if (out_n === 1'b1)
        hn++;
      if (out_p !== 1'b0 && out_n !== 1'b0)
        hb++;
    end
    chk(16'(hp), 16'(exp_p));
    chk(16'(hn), 16'(exp_n));
    chk(16'(hb), 16'h0000);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge ref_clk);
    errors++;
    test_done();
  end

  initial
  begin
    rstn = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    errors = 0;
    check_count = 0;
    rows[0] = '{ftpwm_pkg::ADDR_PERIOD, 16'h0000, 16'h0001};
    rows[1] = '{ftpwm_pkg::ADDR_PERIOD, 16'h0005, 16'h0005};
    rows[2] = '{ftpwm_pkg::ADDR_CMP_A, 16'h0002, 16'h0002};
    rows[3] = '{ftpwm_pkg::ADDR_CMP_B, 16'h0004, 16'h0004};
    rows[4] = '{ftpwm_pkg::ADDR_DEAD, 16'h0001, 16'h0001};
    rows[5] = '{ftpwm_pkg::ADDR_INT_MASK, 16'h0005, 16'h0005};
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    rd_reg(ftpwm_pkg::ADDR_PERIOD);
    chk(got, ftpwm_pkg::RST_PERIOD);
    rd_reg(ftpwm_pkg::ADDR_CMP_A);
    chk(got, ftpwm_pkg::ALL_ONES);
    rd_reg(4'hf);
    chk(got, 16'h0000);
    foreach (rows[i])
    begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a);
      chk(got, rows[i].e);
    end
    // counting, period event and sticky interrupt
    blk_reset();
    wr_reg(ftpwm_pkg::ADDR_PERIOD, 16'h0003);
    wr_reg(ftpwm_pkg::ADDR_INT_MASK, 16'h0001);
    wr_reg(ftpwm_pkg::ADDR_CTRL, 16'h0001);
    for (int n = 0; n < 20 && irq !== 1'b1; n++)
      @(posedge ref_clk);
    chk({15'h0000, irq}, 16'h0001);
    rd_reg(ftpwm_pkg::ADDR_COUNTER);
    chk({15'h0000, got <= 16'h0003}, 16'h0001);
    rd_reg(ftpwm_pkg::ADDR_COUNTER);
    chk({15'h0000, got <= 16'h0003}, 16'h0001);
    rd_reg(ftpwm_pkg::ADDR_INT_STAT);
    chk({15'h0000, got[0]}, 16'h0001);
    wr_reg(ftpwm_pkg::ADDR_CTRL, 16'h0002);
    repeat (3) @(posedge ref_clk);
    chk({15'h0000, irq}, 16'h0001);
    wr_reg(ftpwm_pkg::ADDR_INT_CLR, 16'h000f);
    repeat (2) @(posedge ref_clk);
    chk({15'h0000, irq}, 16'h0000);
    // sampled edge trigger starts the counter
    blk_reset();
    wr_reg(ftpwm_pkg::ADDR_PERIOD, 16'h0003);
    wr_reg(ftpwm_pkg::ADDR_TRIG, 16'h0001);
    u_ftpwm_trig_src.pulse(0, 3);
    repeat (3) @(posedge ref_clk);
    rd_reg(ftpwm_pkg::ADDR_CTRL);
    chk({15'h0000, got[0]}, 16'h0001);
    // emergency and start on one source: never runs
    blk_reset();
    wr_reg(ftpwm_pkg::ADDR_TRIG, 16'h0057);
    wr_reg(ftpwm_pkg::ADDR_CTRL, 16'h0001);
    u_ftpwm_trig_src.hold(1, 1'b1);
    repeat (5) @(posedge ref_clk);
    rd_reg(ftpwm_pkg::ADDR_CTRL);
    chk({15'h0000, got[0]}, 16'h0000);
    rd_reg(ftpwm_pkg::ADDR_COUNTER);
    chk(got, 16'h0000);
    u_ftpwm_trig_src.hold(1, 1'b0);
    // one-shot level start outlives a stop request
    blk_reset();
    wr_reg(ftpwm_pkg::ADDR_MODE, 16'h0004);
    wr_reg(ftpwm_pkg::ADDR_PERIOD, 16'h0003);
    wr_reg(ftpwm_pkg::ADDR_TRIG, 16'h002d);
    u_ftpwm_trig_src.hold(2, 1'b1);
    repeat (4) @(posedge ref_clk);
    wr_reg(ftpwm_pkg::ADDR_CTRL, 16'h0002);
    repeat (6) @(posedge ref_clk);
    rd_reg(ftpwm_pkg::ADDR_CTRL);
    chk({15'h0000, got[0]}, 16'h0001);
    u_ftpwm_trig_src.hold(2, 1'b0);
    // timer, dual compare and dead-time output shapes
    pwm_run(16'h0000, 16'h0000, 6, 6);
    pwm_run(16'h0001, 16'h0000, 4, 8);
    pwm_run(16'h0002, 16'h0001, 4, 4);
    test_done();
  end
endmodule
